// ---- logic/bpt_trigger.sv ----
// breakpoint trigger comparators, level sequencing and register file
`timescale 1ns/100ps
`include "bpt_defines.svh"
module bpt_trigger
  import bpt_pkg::*;
(
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_in,
  input  wire logic [`BPT_ADDR_W-1:0] reg_addr_in,
  input  wire logic [31:0]           reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic      [31:0]           reg_rdata_out,
  input  wire logic                  pc_valid_in,
  input  wire logic [31:0]           pc_in,
  input  wire bpt_bus_t              bus_in,
  input  wire logic                  halt_taken_in,
  output logic                       pending_halt_out,
  output logic                       debug_irq_out,
  output logic      [3:0]            debug_trace_data_out
);

  // ****************************************
  // register file
  // ****************************************
  logic [31:0] pc_match_address_q;
  logic [31:0] pc_match_mask_q;
  logic [31:0] trigger_config_q;
  logic [31:0] address_bound_low_q;
  logic [31:0] address_bound_high_q;
  logic [31:0] data_match_value_q;
  logic [31:0] data_match_mask_q;
  logic [3:0]  trigger_status_q;
  logic [3:0]  trigger_status_d;
  logic        cfg_wr;

  assign cfg_wr = reg_wr_in && (reg_addr_in == `BPT_OFS_CONFIG);

  // comparisons stay live while these load
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      pc_match_address_q   <= `BPT_RST_WORD;
      pc_match_mask_q      <= `BPT_RST_WORD;
      trigger_config_q     <= `BPT_RST_WORD;
      address_bound_low_q  <= `BPT_RST_WORD;
      address_bound_high_q <= `BPT_RST_WORD;
      data_match_value_q   <= `BPT_RST_WORD;
      data_match_mask_q    <= `BPT_RST_WORD;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        `BPT_OFS_PC_ADDR:   pc_match_address_q   <= reg_wdata_in;
        `BPT_OFS_PC_MASK:   pc_match_mask_q      <= reg_wdata_in;
        `BPT_OFS_CONFIG:    trigger_config_q     <= reg_wdata_in;
        `BPT_OFS_BND_LOW:   address_bound_low_q  <= reg_wdata_in;
        `BPT_OFS_BND_HIGH:  address_bound_high_q <= reg_wdata_in;
        `BPT_OFS_DATA_VAL:  data_match_value_q   <= reg_wdata_in;
        `BPT_OFS_DATA_MASK: data_match_mask_q    <= reg_wdata_in;
        default:            ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      reg_rdata_out <= `BPT_RST_WORD;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `BPT_OFS_PC_ADDR:   reg_rdata_out <= pc_match_address_q;
        `BPT_OFS_PC_MASK:   reg_rdata_out <= pc_match_mask_q;
        `BPT_OFS_CONFIG:    reg_rdata_out <= trigger_config_q;
        `BPT_OFS_BND_LOW:   reg_rdata_out <= address_bound_low_q;
        `BPT_OFS_BND_HIGH:  reg_rdata_out <= address_bound_high_q;
        `BPT_OFS_DATA_VAL:  reg_rdata_out <= data_match_value_q;
        `BPT_OFS_DATA_MASK: reg_rdata_out <= data_match_mask_q;
        `BPT_OFS_STATUS:    reg_rdata_out <= {28'h0000000, trigger_status_q};
        default:            reg_rdata_out <= `BPT_RST_WORD;
      endcase
    end
    else
      reg_rdata_out <= `BPT_RST_WORD;
  end

  // ****************************************
  // per-level condition evaluation
  // ****************************************
  logic [1:0] resp;
  bpt_level_t lvl [2];
  logic [1:0] lvl_hit;
  logic       pc_in_region;
  logic [31:0] data_eq_bits;
  logic       addr_in_range;
  logic       addr_low_eq;
  logic [6:0] lane_match;
  logic [6:0] lane_active;

  // response field lives in the upper half only; combine bits sit at 15 and 14
  assign resp    = trigger_config_q[31:30];
  assign lvl[0]  = {trigger_config_q[14], trigger_config_q[13:0]};
  assign lvl[1]  = {trigger_config_q[15], trigger_config_q[29:16]};

  assign pc_in_region = (((pc_in ^ pc_match_address_q) & ~pc_match_mask_q) == 32'h0000_0000);
  assign data_eq_bits = ~((bus_in.data ^ data_match_value_q) & ~data_match_mask_q);
  assign addr_in_range = (bus_in.addr >= address_bound_low_q) && (bus_in.addr <= address_bound_high_q);
  assign addr_low_eq   = (bus_in.addr == address_bound_low_q);

  // lane order: long, low half, high half, byte0 (D7:0), byte1, byte2, byte3 (D31:24)
  always_comb
  begin
    lane_match[6] = &data_eq_bits;
    lane_match[5] = &data_eq_bits[15:0];
    lane_match[4] = &data_eq_bits[31:16];
    lane_match[3] = &data_eq_bits[7:0];
    lane_match[2] = &data_eq_bits[15:8];
    lane_match[1] = &data_eq_bits[23:16];
    lane_match[0] = &data_eq_bits[31:24];
    lane_active[6] = (bus_in.size == BPT_SZ_LONG);
    lane_active[5] = (bus_in.size == BPT_SZ_WORD) && bus_in.addr[1];
    lane_active[4] = (bus_in.size == BPT_SZ_WORD) && !bus_in.addr[1];
    lane_active[3] = (bus_in.size == BPT_SZ_BYTE) && (bus_in.addr[1:0] == 2'b11);
    lane_active[2] = (bus_in.size == BPT_SZ_BYTE) && (bus_in.addr[1:0] == 2'b10);
    lane_active[1] = (bus_in.size == BPT_SZ_BYTE) && (bus_in.addr[1:0] == 2'b01);
    lane_active[0] = (bus_in.size == BPT_SZ_BYTE) && (bus_in.addr[1:0] == 2'b00);
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_level
      logic pc_cond;
      logic addr_cond;
      logic data_cond;
      logic ad_cond;
      logic addr_en;
      logic data_en;
      assign pc_cond   = pc_valid_in && lvl[g].pc_enable && (pc_in_region ^ lvl[g].pc_invert);
      assign addr_en   = lvl[g].outside_range || lvl[g].inside_range || lvl[g].low_equal;
      assign addr_cond = (lvl[g].outside_range && !addr_in_range)
                      || (lvl[g].inside_range && addr_in_range)
                      || (lvl[g].low_equal && addr_low_eq);
      assign data_en   = |lvl[g].lane_enables;
      assign data_cond = !data_en
                      || (|(lvl[g].lane_enables & lane_active & (lane_match ^ {7{lvl[g].data_invert}})));
      assign ad_cond   = bus_in.valid && addr_en && addr_cond && data_cond;
      // combine: 0 = or, 1 = and of the two conditions
      assign lvl_hit[g] = lvl[g].global_enable
                       && (lvl[g].combine_and ? (pc_cond && ad_cond) : (pc_cond || ad_cond));
    end
  endgenerate

  // ****************************************
  // level sequencing and response
  // ****************************************
  bpt_state_t state_q;
  logic       two_level;
  logic       done;

  assign two_level = lvl[1].global_enable;
  assign done = (state_q == BPT_ARM_L1) ? (lvl_hit[0] && !two_level) : lvl_hit[1];

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      state_q <= BPT_ARM_L1;
    else
    begin
      // a trigger in the cycle of a config write wins over the restart
      case (state_q)
        BPT_ARM_L1: if (two_level && lvl_hit[0]) state_q <= BPT_ARM_L2;
        BPT_ARM_L2: if (lvl_hit[1] || cfg_wr) state_q <= BPT_ARM_L1;
        default:    state_q <= BPT_ARM_L1;
      endcase
    end
  end

  always_comb
  begin
    trigger_status_d = trigger_status_q;
    if (cfg_wr)
      trigger_status_d = `BPT_ST_IDLE;
    if (state_q == BPT_ARM_L1 && two_level && lvl_hit[0])
      trigger_status_d = `BPT_ST_ARMED;
    if (done)
      trigger_status_d = two_level ? `BPT_ST_L2_HIT : `BPT_ST_L1_HIT;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      trigger_status_q <= `BPT_ST_IDLE;
    else
      trigger_status_q <= trigger_status_d;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      debug_trace_data_out <= `BPT_ST_IDLE;
    else
      debug_trace_data_out <= trigger_status_d;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      pending_halt_out <= 1'b0;
      debug_irq_out    <= 1'b0;
    end
    else
    begin
      if (done && resp == `BPT_RESP_HALT)
        pending_halt_out <= 1'b1;
      else if (halt_taken_in)
        pending_halt_out <= 1'b0;
      debug_irq_out <= done && (resp == `BPT_RESP_IRQ);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_cfg_clear;
    @(posedge sys_clk_in) disable iff (reset_in)
      cfg_wr && !done && !(lvl_hit[0] && two_level) |=> trigger_status_q == `BPT_ST_IDLE;
  endproperty
  a_cfg_clear: assert property (p_cfg_clear) else $error("status not cleared by config write");

  property p_trace;
    @(posedge sys_clk_in) disable iff (reset_in)
      done |=> debug_trace_data_out != `BPT_ST_IDLE;
  endproperty
  a_trace: assert property (p_trace) else $error("completed trigger not on trace");

  property p_halt;
    @(posedge sys_clk_in) disable iff (reset_in)
      done && resp == `BPT_RESP_HALT |=> pending_halt_out;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not made pending");

  property p_halt_hold;
    @(posedge sys_clk_in) disable iff (reset_in)
      pending_halt_out && !halt_taken_in |=> pending_halt_out;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("pending halt dropped early");

  property p_irq;
    @(posedge sys_clk_in) disable iff (reset_in)
      debug_irq_out |-> $past(done) && $past(resp) == `BPT_RESP_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without irq response");

  property p_enable;
    @(posedge sys_clk_in) disable iff (reset_in)
      !lvl[0].global_enable |-> !lvl_hit[0];
  endproperty
  a_enable: assert property (p_enable) else $error("disabled level fired");

  property p_pc_hit;
    @(posedge sys_clk_in) disable iff (reset_in)
      pc_valid_in && lvl[0].global_enable && lvl[0].pc_enable && !lvl[0].pc_invert && pc_in == pc_match_address_q
      |-> lvl_hit[0] || lvl[0].combine_and;
  endproperty
  a_pc_hit: assert property (p_pc_hit) else $error("exact pc match missed");

  property p_seq;
    @(posedge sys_clk_in) disable iff (reset_in)
      state_q == BPT_ARM_L1 && two_level |-> !done;
  endproperty
  a_seq: assert property (p_seq) else $error("level two completed before level one");

endmodule : bpt_trigger

// ---- pkg/bpt_defines.svh ----
// register offsets, field positions and encodings of the breakpoint trigger logic
//
// Functional notes
// - hold 32-bit pc match address as reference
// - compare pc bits where mask bit zero
// - single-level or two-level triggering supported
// - upper half level two, lower level one; level-two combine bit at 15
// - config write clears trigger status bits; a trigger or arming in the write cycle sets status instead
// - comparison stays live during register loads
// - response field: trace, halt, interrupt, reserved
// - completed trigger always shown on trace
// - combine bit selects or/and of conditions
// - per-level global enable gates its trigger
// - seven lane enables; all clear disables data
// - long, low half, high half lanes
// - byte enables lowest to highest order
// - invert bit inverts every data comparator
// - three address modes; all clear disables
// - outside-range mode true beyond bounds
// - inside-range mode inclusive of both bounds
// - low-equal mode matches low bound exactly
// - pc enable brings pc condition in
// - pc invert selects outside masked region
// - data compare where mask bit zero
// - byte lanes placed by address low bits
// - halt response raises pending halt first
`ifndef BPT_DEFINES_SVH
`define BPT_DEFINES_SVH
`define BPT_ADDR_W        4
`define BPT_OFS_PC_ADDR   4'h0
`define BPT_OFS_PC_MASK   4'h1
`define BPT_OFS_CONFIG    4'h2
`define BPT_OFS_BND_LOW   4'h3
`define BPT_OFS_BND_HIGH  4'h4
`define BPT_OFS_DATA_VAL  4'h5
`define BPT_OFS_DATA_MASK 4'h6
`define BPT_OFS_STATUS    4'h7
`define BPT_RST_WORD      32'h0000_0000
`define BPT_RESP_TRACE    2'h0
`define BPT_RESP_HALT     2'h1
`define BPT_RESP_IRQ      2'h2
`define BPT_ST_IDLE       4'h0
`define BPT_ST_L1_HIT     4'h1
`define BPT_ST_L2_HIT     4'h2
`define BPT_ST_ARMED      4'h3
`endif

// ---- pkg/bpt_pkg.sv ----
// types shared by the breakpoint trigger logic
package bpt_pkg;
  typedef struct packed {
    logic       combine_and;
    logic       global_enable;
    logic [6:0] lane_enables;
    logic       data_invert;
    logic       outside_range;
    logic       inside_range;
    logic       low_equal;
    logic       pc_enable;
    logic       pc_invert;
  } bpt_level_t;
  typedef struct packed {
    logic [1:0] response;
    logic       combine_and;
    logic       global_enable;
    logic [6:0] lane_enables;
    logic       data_invert;
    logic       outside_range;
    logic       inside_range;
    logic       low_equal;
    logic       pc_enable;
    logic       pc_invert;
  } bpt_half_t;
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
    logic [1:0]  size;
  } bpt_bus_t;
  typedef enum logic [1:0] {
    BPT_SZ_LONG = 2'b00,
    BPT_SZ_BYTE = 2'b01,
    BPT_SZ_WORD = 2'b10
  } bpt_size_t;
  typedef enum logic [1:0] {
    BPT_ARM_L1 = 2'b00,
    BPT_ARM_L2 = 2'b01
  } bpt_state_t;
endpackage : bpt_pkg

// ---- bench/bpt_core_model.sv ----
// core and local bus model facing the breakpoint trigger logic
`timescale 1ns/100ps
module bpt_core_model
  import bpt_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        issue_in,
  input  wire logic        slow_in,
  input  wire logic [31:0] pc_req_in,
  input  wire bpt_bus_t    bus_req_in,
  input  wire logic        pending_halt_in,
  output logic             pc_valid_out,
  output logic      [31:0] pc_out,
  output bpt_bus_t         bus_out,
  output logic             halt_taken_out
);
  logic     [31:0] pc_last_q;
  bpt_bus_t        bus_last_q;
  logic     [2:0]  wait_q;

  // released lines show the inverse of their last value
  assign pc_valid_out = issue_in;
  assign pc_out       = issue_in ? pc_req_in : ~pc_last_q;
  assign bus_out      = bus_req_in.valid ? bus_req_in : {1'b0, ~bus_last_q[65:0]};

  always_ff @(posedge clk_in)
  begin
    if (issue_in)
      pc_last_q <= pc_req_in;
    if (bus_req_in.valid)
      bus_last_q <= bus_req_in;
  end

  // halt taken at a later instruction sample point
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      wait_q         <= 3'h0;
      halt_taken_out <= 1'b0;
    end
    else
    begin
      halt_taken_out <= 1'b0;
      if (pending_halt_in && !halt_taken_out)
      begin
        if (wait_q == (slow_in ? 3'h4 : 3'h1))
        begin
          halt_taken_out <= 1'b1;
          wait_q         <= 3'h0;
        end
        else
          wait_q <= wait_q + 3'h1;
      end
    end
  end
endmodule : bpt_core_model

// ---- bench/testbench.sv ----
// self-checking bench for the breakpoint trigger logic
`timescale 1ns/100ps
module testbench
  import bpt_pkg::*;
;
  logic        sys_clk_in = 1'b0, reset_in = 1'b1;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, pc_in, pc_req = 32'h0;
  logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, issue = 1'b0, slow = 1'b0;
  logic        look = 1'b0, rd_seen = 1'b0, pc_valid_in, halt_taken_in;
  logic        pending_halt_out, debug_irq_out;
  logic [3:0]  debug_trace_data_out;
  bpt_bus_t    bus_in, bus_req = '0;
  logic [31:0] rd_q[$], tr_q[$], a, m, v;
  int          bad_count = 0, checks_done = 0;
  logic [4:0]  am[8] = '{5'h08, 5'h08, 5'h08, 5'h10, 5'h10, 5'h04, 5'h04, 5'h00};
  logic [31:0] aa[8] = '{32'h1000, 32'h1FFF, 32'h2000, 32'h0FFF, 32'h1800, 32'h1000, 32'h1004, 32'h1000};
  logic        ah[8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  always #25 sys_clk_in = ~sys_clk_in;

  bpt_trigger uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .pc_valid_in(pc_valid_in), .pc_in(pc_in), .bus_in(bus_in),
    .halt_taken_in(halt_taken_in), .pending_halt_out(pending_halt_out),
    .debug_irq_out(debug_irq_out), .debug_trace_data_out(debug_trace_data_out));

  bpt_core_model core (.clk_in(sys_clk_in), .reset_in(reset_in), .issue_in(issue), .slow_in(slow),
    .pc_req_in(pc_req), .bus_req_in(bus_req), .pending_halt_in(pending_halt_out),
    .pc_valid_out(pc_valid_in), .pc_out(pc_in), .bus_out(bus_in), .halt_taken_out(halt_taken_in));

  // ****************************************
  // result watcher and tasks
  // ****************************************
  always @(posedge sys_clk_in) rd_seen <= reg_rd_in;

  always @(negedge sys_clk_in)
  begin
    if (rd_seen)
      cmp(rd_q.pop_front(), reg_rdata_out);
    if (look)
      cmp(tr_q.pop_front(), {26'h0, debug_trace_data_out, pending_halt_out, debug_irq_out});
  end

  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp

  task automatic stop_test;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= ad;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] ad, input logic [31:0] e);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= ad;
    rd_q.push_back(e);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
  endtask : rd

  task automatic run(input logic iv, input logic [31:0] pc, input bpt_bus_t b, input logic [5:0] e);
    @(posedge sys_clk_in);
    issue <= iv;
    pc_req <= pc;
    bus_req <= b;
    @(posedge sys_clk_in);
    issue <= 1'b0;
    bus_req.valid <= 1'b0;
    look <= 1'b1;
    tr_q.push_back({26'h0, e});
    @(posedge sys_clk_in);
    look <= 1'b0;
  endtask : run

  task automatic settle;
    int n;
    n = 0;
    while (pending_halt_out !== 1'b0 && n < 20)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n == 20)
    begin
      bad_count++;
      stop_test();
    end
  endtask : settle

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    void'($urandom(4));
    repeat (10) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 10; i++) rd(i[3:0], 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      v = $urandom;
      if (i != 2)
      begin
        wr(i[3:0], v);
        rd(i[3:0], (i < 7) ? v : 32'h0);
      end
    end
    a = $urandom;
    m = $urandom & 32'h0000_FF00;
    wr(4'h0, a);
    wr(4'h1, m);
    for (int r = 0; r < 4; r++)
    begin
      slow <= 1'(r);
      wr(4'h2, {r[1:0], 30'h0000_2002});
      run(1'b1, a ^ 32'h1, '0, 6'h00);
      run(1'b1, a ^ (m & $urandom), '0, {4'h1, r == 1, r == 2});
      settle();
    end
    wr(4'h2, 32'h0000_2002);
    run(1'b0, a, '0, 6'h00);
    wr(4'h2, 32'h0000_0002);
    run(1'b1, a, '0, 6'h00);
    wr(4'h2, 32'h0000_2003);
    run(1'b1, a, '0, 6'h00);
    run(1'b1, a ^ 32'h1, '0, 6'h04);
    wr(4'h2, 32'h0);
    wr(4'h3, 32'h0000_1000);
    wr(4'h4, 32'h0000_1FFF);
    for (int i = 0; i < 8; i++)
    begin
      wr(4'h2, {27'h100, am[i]});
      run(1'b1, ~a, '{1'b1, aa[i], $urandom, BPT_SZ_LONG}, {3'h0, ah[i], 2'h0});
    end
    wr(4'h2, 32'h0);
    wr(4'h3, 32'h0);
    wr(4'h4, 32'hFFFF_FFFF);
    wr(4'h5, 32'h0000_00A5);
    wr(4'h6, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h2, i[1] ? 32'h0000_2228 : 32'h0000_2208);
      run(1'b1, ~a, '{1'b1, 32'h3, {24'h0, i[0] ? 8'hA4 : 8'hA5}, BPT_SZ_BYTE},
          {3'h0, i[1] ^ !i[0], 2'h0});
    end
    wr(4'h2, 32'h6002_2002);
    run(1'b1, a, '0, 6'h0C);
    run(1'b1, a, '0, 6'h0A);
    settle();
    stop_test();
  end
endmodule : testbench
